//--- inc/spl_pkg.sv
`default_nettype none
package spl_pkg;
  localparam int SPL_SECTORS = 16;
  localparam int SPL_SEC_W = 4;
  // sector index sits in address bits 19:16 (64-Kbyte sectors)
  localparam int SPL_SEC_LSB = 16;
  localparam logic [7:0] SPL_OP_READ_PROT = 8'h3C;
  localparam logic [7:0] SPL_OP_PROTECT = 8'h36;
  localparam logic [7:0] SPL_OP_UNPROTECT = 8'h39;
  localparam logic [7:0] SPL_OP_WRITE_STATUS = 8'h01;
  localparam int SPL_ADDR_BYTES = 3;
  localparam logic [1:0] SPL_LAST_ADDR = 2'h2;
  localparam logic [2:0] SPL_LAST_BIT = 3'h7;
  localparam int SPL_LOCK_POS = 7;
  localparam int SPL_GLB_HI = 5;
  localparam int SPL_GLB_LO = 2;
  localparam logic [3:0] SPL_GLB_UNPROT = 4'h0;
  localparam logic [3:0] SPL_GLB_PROT = 4'hF;
  localparam logic [15:0] SPL_PROT_RST = 16'hFFFF;
  localparam logic SPL_LOCK_RST = 1'b0;
  localparam logic [1:0] SPL_SUM_NONE = 2'h0;
  localparam logic [1:0] SPL_SUM_SOME = 2'h1;
  localparam logic [1:0] SPL_SUM_ALL = 2'h3;
  typedef enum logic [2:0] {
    SPL_ST_CMD,
    SPL_ST_ADDR,
    SPL_ST_READ,
    SPL_ST_STATUS,
    SPL_ST_IGNORE
  } spl_state_t;
endpackage
`default_nettype wire

//--- logic/spl_sector_protect.sv
`default_nettype none
module spl_sector_protect
  import spl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic si_i,
  input wire logic wp_n_i,
  output logic so_o,
  output logic so_oe_n_o,
  output logic [SPL_SECTORS-1:0] prot_bits_o,
  output logic protect_regs_lock_bit_o,
  output logic [1:0] soft_protect_summary_bits_o,
  output logic hw_locked_o
);

  // sector field position inside the first address byte
  localparam int SPL_SEC_OFS = SPL_SEC_LSB - 8 * (SPL_ADDR_BYTES - 1);

  spl_state_t state_r, state_nxt;
  logic sclk_r, sclk_nxt;
  logic [2:0] bit_cnt_r, bit_cnt_nxt;
  logic [1:0] byte_cnt_r, byte_cnt_nxt;
  logic [7:0] shift_r, shift_nxt;
  logic [7:0] op_r, op_nxt;
  logic [SPL_SEC_W-1:0] sec_r, sec_nxt;
  logic [SPL_SECTORS-1:0] prot_r, prot_nxt;
  logic lock_r, lock_nxt;
  logic so_r, so_nxt;
  logic oe_n_r, oe_n_nxt;
  logic [1:0] sum_r, sum_nxt;
  logic hwl_r, hwl_nxt;

  // decoded strobes shared by the groups
  logic rise;
  logic fall;
  logic [7:0] byte_in;
  logic byte_done;
  logic cmd_done;
  logic sector_done;
  logic status_done;
  logic hw_lock;
  logic [3:0] glb;

  function automatic logic [1:0] spl_summary(
    input logic [SPL_SECTORS-1:0] p
  );
    if (&p) begin
      spl_summary = SPL_SUM_ALL;
    end else if (|p) begin
      spl_summary = SPL_SUM_SOME;
    end else begin
      spl_summary = SPL_SUM_NONE;
    end
  endfunction

  function automatic logic spl_is_sector_op(
    input logic [7:0] op
  );
    spl_is_sector_op = (op == SPL_OP_PROTECT) || (op == SPL_OP_UNPROTECT);
  endfunction

  function automatic logic [SPL_SECTORS-1:0] spl_glb_apply(
    input logic [SPL_SECTORS-1:0] p,
    input logic [3:0] g
  );
    if (g == SPL_GLB_UNPROT) begin
      spl_glb_apply = '0;
    end else if (g == SPL_GLB_PROT) begin
      spl_glb_apply = '1;
    end else begin
      spl_glb_apply = p;
    end
  endfunction

  assign rise = sclk_i & ~sclk_r;
  assign fall = ~sclk_i & sclk_r;
  assign byte_in = {shift_r[6:0], si_i};
  // byte completes on eighth rising edge
  assign byte_done = ~cs_n_i & rise & (bit_cnt_r == SPL_LAST_BIT);
  assign cmd_done = byte_done & (state_r == SPL_ST_CMD);
  assign sector_done = byte_done & (state_r == SPL_ST_ADDR) &
                       (byte_cnt_r == SPL_LAST_ADDR) &
                       spl_is_sector_op(op_r);
  assign status_done = byte_done & (state_r == SPL_ST_STATUS);
  // pin acts only with lock set
  assign hw_lock = ~wp_n_i & lock_r;
  assign glb = byte_in[SPL_GLB_HI:SPL_GLB_LO];

  // serial link: edge copy, bit and byte counters
  always_comb begin
    sclk_nxt = sclk_i;
    bit_cnt_nxt = bit_cnt_r;
    byte_cnt_nxt = byte_cnt_r;
    shift_nxt = shift_r;
    if (cs_n_i) begin
      bit_cnt_nxt = '0;
      byte_cnt_nxt = '0;
    end else begin
      if (rise) begin
        shift_nxt = byte_in;
        bit_cnt_nxt = bit_cnt_r + 3'h1;
      end
      if (cmd_done) begin
        byte_cnt_nxt = '0;
      end else if (byte_done && state_r == SPL_ST_ADDR) begin
        byte_cnt_nxt = byte_cnt_r + 2'h1;
      end
    end
  end

  // command decoder
  always_comb begin
    state_nxt = state_r;
    op_nxt = op_r;
    sec_nxt = sec_r;
    if (cs_n_i) begin
      state_nxt = SPL_ST_CMD;
    end else begin
      unique case (state_r)
        SPL_ST_CMD: begin
          if (byte_done) begin
            op_nxt = byte_in;
            if (byte_in == SPL_OP_READ_PROT ||
                spl_is_sector_op(byte_in)) begin
              state_nxt = SPL_ST_ADDR;
            end else if (byte_in == SPL_OP_WRITE_STATUS) begin
              state_nxt = SPL_ST_STATUS;
            end else begin
              state_nxt = SPL_ST_IGNORE;
            end
          end
        end
        SPL_ST_ADDR: begin
          if (byte_done) begin
            // sector bits in first address byte
            if (byte_cnt_r == '0) begin
              sec_nxt = byte_in[SPL_SEC_OFS+SPL_SEC_W-1:SPL_SEC_OFS];
            end
            if (byte_cnt_r == SPL_LAST_ADDR) begin
              if (op_r == SPL_OP_READ_PROT) begin
                state_nxt = SPL_ST_READ;
              end else begin
                state_nxt = SPL_ST_IGNORE;
              end
            end
          end
        end
        SPL_ST_READ: begin
          state_nxt = SPL_ST_READ;
        end
        SPL_ST_STATUS: begin
          if (byte_done) begin
            state_nxt = SPL_ST_IGNORE;
          end
        end
        SPL_ST_IGNORE: begin
          state_nxt = SPL_ST_IGNORE;
        end
        default: begin
          state_nxt = SPL_ST_IGNORE;
        end
      endcase
    end
  end

  // protection bits and lock bit
  always_comb begin
    prot_nxt = prot_r;
    lock_nxt = lock_r;
    if (sector_done && !lock_r) begin
      prot_nxt[sec_r] = (op_r == SPL_OP_PROTECT);
    end
    // status write ignored under hardware lock
    if (status_done && !hw_lock) begin
      lock_nxt = byte_in[SPL_LOCK_POS];
      // global only when lock was clear
      if (!lock_r) begin
        prot_nxt = spl_glb_apply(prot_r, glb);
      end
    end
  end

  // serial output and its enable
  always_comb begin
    so_nxt = so_r;
    oe_n_nxt = oe_n_r;
    if (cs_n_i) begin
      // output floats once chip select rises
      oe_n_nxt = 1'b1;
      so_nxt = 1'b0;
    end else if (state_r == SPL_ST_READ && fall) begin
      // stored bit on every falling edge
      // first byte is always valid here
      so_nxt = prot_r[sec_r];
      oe_n_nxt = 1'b0;
    end
  end

  // status outputs
  always_comb begin
    sum_nxt = spl_summary(prot_nxt);
    hwl_nxt = ~wp_n_i & lock_nxt;
  end

  // link registers
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sclk_r <= 1'b0;
      bit_cnt_r <= '0;
      byte_cnt_r <= '0;
      shift_r <= '0;
    end else begin
      sclk_r <= sclk_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      byte_cnt_r <= byte_cnt_nxt;
      shift_r <= shift_nxt;
    end
  end

  // decoder registers
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      state_r <= SPL_ST_CMD;
      op_r <= '0;
      sec_r <= '0;
    end else begin
      state_r <= state_nxt;
      op_r <= op_nxt;
      sec_r <= sec_nxt;
    end
  end

  // protection registers
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      prot_r <= SPL_PROT_RST;
      lock_r <= SPL_LOCK_RST;
    end else begin
      prot_r <= prot_nxt;
      lock_r <= lock_nxt;
    end
  end

  // output registers
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      so_r <= 1'b0;
      oe_n_r <= 1'b1;
    end else begin
      so_r <= so_nxt;
      oe_n_r <= oe_n_nxt;
    end
  end

  // status registers
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      sum_r <= SPL_SUM_ALL;
      hwl_r <= 1'b0;
    end else begin
      sum_r <= sum_nxt;
      hwl_r <= hwl_nxt;
    end
  end

  assign so_o = so_r;
  assign so_oe_n_o = oe_n_r;
  assign prot_bits_o = prot_r;
  assign protect_regs_lock_bit_o = lock_r;
  assign soft_protect_summary_bits_o = sum_r;
  assign hw_locked_o = hwl_r;

endmodule
`default_nettype wire

//--- testbench/spl_checker.sv
`default_nettype none
module spl_checker
  import spl_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic rstn_i,
  input wire logic cs_n_i,
  input wire logic sclk_i,
  input wire logic si_i,
  input wire logic wp_n_i,
  input wire logic so_o,
  input wire logic so_oe_n_o,
  input wire logic [SPL_SECTORS-1:0] prot_bits_o,
  input wire logic protect_regs_lock_bit_o,
  input wire logic [1:0] soft_protect_summary_bits_o,
  input wire logic hw_locked_o
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);
  a_hw_lock_eq: assert property ($stable(protect_regs_lock_bit_o) |->
    hw_locked_o == (!$past(wp_n_i) && protect_regs_lock_bit_o))
    else $error("lock state mismatch");
  a_cs_float: assert property (cs_n_i |=> so_oe_n_o)
    else $error("output not floated");
  a_read_steady: assert property (!so_oe_n_o && !$past(so_oe_n_o)
    |-> $stable(so_o)) else $error("read value changed");
  a_drive_after_fall: assert property ($fell(so_oe_n_o) |->
    !$past(sclk_i) && $past(sclk_i, 2)) else $error("drive not on fall");
  a_summary_code: assert property (soft_protect_summary_bits_o ==
    (&prot_bits_o ? 2'h3 : (|prot_bits_o ? 2'h1 : 2'h0)))
    else $error("summary mismatch");
  a_hw_frozen: assert property (!wp_n_i && protect_regs_lock_bit_o
    |=> protect_regs_lock_bit_o) else $error("locked bit changed");
  a_soft_frozen: assert property (protect_regs_lock_bit_o
    |=> $stable(prot_bits_o)) else $error("locked sectors changed");
  a_change_on_clock: assert property ($changed(prot_bits_o)
    |-> $past(sclk_i)) else $error("change without command");
endmodule
`default_nettype wire

//--- testbench/spl_host.sv
`default_nettype none
module spl_host (
  input wire logic sys_clk_i,
  input wire logic so_i,
  output logic cs_n_o,
  output logic sclk_o,
  output logic si_o
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    cs_n_o = 1'b1;
    sclk_o = 1'b0;
    si_o = 1'b0;
  end
  task automatic shift_bit(input logic b, output logic r);
    @(negedge sys_clk_i);
    sclk_o = 1'b0;
    si_o = b;
    repeat (2) @(negedge sys_clk_i);
    r = so_i;
    sclk_o = 1'b1;
  endtask
  task automatic frame(input logic [31:0] w, input int nw, input int nr,
                       output logic [15:0] rd);
    logic r;
    rd = '0;
    cs_n_o = 1'b0;
    for (int i = nw - 1; i >= 0; i--) shift_bit(w[i], r);
    // slow clock, first byte already valid
    for (int i = 0; i < nr; i++) begin
      shift_bit(~si_o, r);
      rd = {rd[14:0], r};
    end
    @(negedge sys_clk_i);
    sclk_o = 1'b0;
    @(negedge sys_clk_i);
    cs_n_o = 1'b1;
    si_o = ~si_o;
  endtask
endmodule
`default_nettype wire

//--- testbench/spl_sector_protect_bench.sv
`default_nettype none
module spl_sector_protect_bench import spl_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  logic sys_clk_i, rstn_i, cs_n_i, sclk_i, si_i, wp_n_i, so_o, so_oe_n_o;
  logic [15:0] prot_bits_o, mprot;
  logic protect_regs_lock_bit_o, hw_locked_o, mlock;
  logic [1:0] soft_protect_summary_bits_o;
  int bad_count = 0;
  int checks = 0;
  spl_sector_protect dut (.*);
  spl_host h (.sys_clk_i, .so_i(so_o), .cs_n_o(cs_n_i), .sclk_o(sclk_i),
              .si_o(si_i));
  initial begin
    sys_clk_i = 1'b0;
    forever #5 sys_clk_i = ~sys_clk_i;
  end
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    checks++;
    if (g !== e) begin
      bad_count++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic report_and_stop;
    $display("checks %0d errors %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic check_state;
    chk("prot", mprot, prot_bits_o);
    chk("lock", 16'(mlock), 16'(protect_regs_lock_bit_o));
    chk("sum", &mprot ? 16'h0003 : 16'(|mprot),
        16'(soft_protect_summary_bits_o));
    chk("hw", 16'(!wp_n_i && mlock), 16'(hw_locked_o));
    chk("oe", 16'h0001, 16'(so_oe_n_o));
  endtask
  initial begin
    repeat (100000) @(posedge sys_clk_i);
    bad_count++;
    report_and_stop();
  end
  initial begin
    logic [7:0] dv [5];
    logic [7:0] ot [4];
    logic [23:0] a;
    logic [7:0] d;
    logic [15:0] rd;
    int op, nr;
    dv = '{8'h00, 8'h7F, 8'hFF, 8'h0F, 8'hF0};
    ot = '{SPL_OP_READ_PROT, SPL_OP_PROTECT, SPL_OP_UNPROTECT, 8'h00};
    void'($urandom(32'h9FD3EBC3));
    rstn_i = 1'b0;
    wp_n_i = 1'b1;
    mprot = 16'hFFFF;
    mlock = 1'b0;
    repeat (20) @(negedge sys_clk_i);
    rstn_i = 1'b1;
    check_state();
    for (int k = 0; k < 80; k++) begin
      @(negedge sys_clk_i);
      wp_n_i = 1'($urandom_range(1));
      a = 24'($urandom);
      op = $urandom_range(4);
      d = dv[$urandom_range(4)];
      nr = $urandom_range(16, 1);
      if (op == 3) h.frame({16'h0000, SPL_OP_WRITE_STATUS, d}, 16, 0, rd);
      else h.frame({ot[(op == 4) ? 3 : op], a}, 32, (op == 0) ? nr : 0, rd);
      if (op == 0) chk("read", mprot[a[19:16]] ? 16'hFFFF >> (16 - nr) :
                       16'h0000, rd);
      else if (op < 3 && !mlock) mprot[a[19:16]] = (op == 1);
      else if (op == 3 && (wp_n_i || !mlock)) begin
        if (!mlock && d[5:2] == 4'h0) mprot = 16'h0000;
        if (!mlock && d[5:2] == 4'hF) mprot = 16'hFFFF;
        mlock = d[7];
      end
      repeat (2) @(negedge sys_clk_i);
      check_state();
    end
    report_and_stop();
  end
endmodule
bind spl_sector_protect spl_checker chk_i (.*);
`default_nettype wire
